// ===== hw/vfic_pkg.sv
// Package with register map, field positions and timing constants
// Summary of operation
// - Only write transfers accepted; no register readback exists.
// - No acknowledge for wrong slave address or invalid subaddress.
// - Data byte after a valid subaddress is always acknowledged.
// - No subaddress auto-increment; each register needs a full cycle.
// - Slave address 90h pin low, 92h pin high, 94h pin open.
// - Subaddress 01h cutoff, 02h input type, 03h operating condition.
// - Cutoff bit 7 range select, bits 6:0 step, default 00h.
// - Input type pairs per channel; upper high direct, else clamp or bias.
// - Operating bit 7 high powers down the analog block.
// - Operating bit 6 selects input bank while bank pin is low.
// - Operating bit 5 halves cutoff of channels 2 and 3 only.
// - Operating bit 4 bypasses filters; cutoff and half ignored then; only half is masked, cutoff outputs still follow the register.
// - New setting applied within 1 us of its acknowledge bit.
// - Fast-mode transfers up to 400 kbit/s supported.
// - Bank pin high selects input B whatever the register bit.
// - Reset loads every register flag with its default.
package vfic_pkg;
    localparam logic [7:0] SLAVE_ADDR_LOW   = 8'h90;
    localparam logic [7:0] SLAVE_ADDR_HIGH  = 8'h92;
    localparam logic [7:0] SLAVE_ADDR_OPEN  = 8'h94;
    localparam logic [7:0] SUB_CUTOFF       = 8'h01;
    localparam logic [7:0] SUB_INPUT_TYPE   = 8'h02;
    localparam logic [7:0] SUB_OPERATING    = 8'h03;
    localparam logic [7:0] CUTOFF_RESET     = 8'h00;
    localparam logic [5:0] INPUT_TYPE_RESET = 6'h00;
    localparam logic [3:0] OPERATING_RESET  = 4'h0;
    localparam int         CUTOFF_RANGE_BIT = 7;
    localparam int         INPUT_TYPE_LSB   = 2;
    localparam int         OPERATING_LSB    = 4;
    localparam int         OP_POWERDOWN     = 3;
    localparam int         OP_BANK          = 2;
    localparam int         OP_HALF          = 1;
    localparam int         OP_BYPASS        = 0;
    localparam int         CLK_PERIOD_PS    = 25000;
    localparam int         APPLY_LIMIT_NS   = 1000;
    localparam int         APPLY_LIMIT_CYC  = (APPLY_LIMIT_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [1:0] ADDR_PIN_LOW     = 2'h0;
    localparam logic [1:0] ADDR_PIN_HIGH    = 2'h1;
    localparam logic [1:0] ADDR_PIN_OPEN    = 2'h2;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_SUB  = 2'b10,
        PH_DATA = 2'b11
    } vfic_phase_e;
endpackage

// ===== hw/vfic_bus_sampler.sv
// Line sampler with start, stop and SCL edge detection
`timescale 1ns/100ps
module vfic_bus_sampler
    import vfic_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bus lines
    input  wire logic sclIn,
    input  wire logic sdaIn,
    // Events
    output logic      sclRise,
    output logic      sclFall,
    output logic      startSeen,
    output logic      stopSeen,
    output logic      sdaLevel
);
    logic sclQ;
    logic sdaQ;

    // Inputs treated as synchronous; one stage for edge detection
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end
        else
        begin
            sclQ <= sclIn;
            sdaQ <= sdaIn;
        end
    end

    assign sclRise   = sclIn & ~sclQ;
    assign sclFall   = ~sclIn & sclQ;
    assign startSeen = sclIn & sclQ & sdaQ & ~sdaIn;
    assign stopSeen  = sclIn & sclQ & ~sdaQ & sdaIn;
    assign sdaLevel  = sdaQ;
endmodule // vfic_bus_sampler

// ===== hw/vfic_control_map.sv
// Maps register flags onto analog control outputs
`timescale 1ns/100ps
module vfic_control_map
    import vfic_pkg::*;
(
    // Register contents
    input  wire logic [7:0] cutoffQ,
    input  wire logic [5:0] inputTypeQ,
    input  wire logic [3:0] operatingQ,
    input  wire logic       inputBankPin,
    // Analog controls
    output logic            cutoffRangeSelect,
    output logic [6:0]      cutoffFineStep,
    output logic [2:0]      chanDirect,
    output logic [2:0]      chanBias,
    output logic            analogPowerdown,
    output logic            inputBankSelect,
    output logic [2:0]      chanHalfCutoff,
    output logic            filterBypass
);
    assign cutoffRangeSelect = cutoffQ[CUTOFF_RANGE_BIT];
    assign cutoffFineStep    = cutoffQ[6:0];

    // Channel 1 uses the top pair
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++)
        begin : g_chan
            assign chanDirect[ch] = inputTypeQ[5 - 2 * ch];
            assign chanBias[ch]   = ~inputTypeQ[5 - 2 * ch] & inputTypeQ[4 - 2 * ch];
        end
    endgenerate

    assign analogPowerdown = operatingQ[OP_POWERDOWN];
    assign inputBankSelect = inputBankPin | operatingQ[OP_BANK];
    // Half cutoff meaningless in bypass, so it is masked there
    assign chanHalfCutoff  = {3{operatingQ[OP_HALF] & ~operatingQ[OP_BYPASS]}} & 3'h6;
    assign filterBypass    = operatingQ[OP_BYPASS];
endmodule // vfic_control_map

// ===== hw/vfic_i2c_ctrl.sv
// Write-only I2C slave holding the three filter control registers
`timescale 1ns/100ps
module vfic_i2c_ctrl
    import vfic_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // I2C pins
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe_n,
    // Strap and direct pins
    input  wire logic [1:0] slaveAddrPin,
    input  wire logic       inputBankPin,
    // Analog controls
    output logic            cutoffRangeSelect,
    output logic [6:0]      cutoffFineStep,
    output logic [2:0]      chanDirect,
    output logic [2:0]      chanBias,
    output logic            analogPowerdown,
    output logic            inputBankSelect,
    output logic [2:0]      chanHalfCutoff,
    output logic            filterBypass
);
    logic        sclRise;
    logic        sclFall;
    logic        startSeen;
    logic        stopSeen;
    logic        sdaLevel;
    vfic_phase_e phase_q;
    logic [7:0]  shift_q;
    logic [3:0]  bitCnt_q;
    logic [7:0]  sub_q;
    logic        ackDrive_q;
    logic [7:0]  cutoff_q;
    logic [5:0]  inputType_q;
    logic [3:0]  operating_q;
    logic [7:0]  ownAddr;
    logic        byteDone;
    logic        subValid;

    vfic_bus_sampler u_sampler (
        .clk       (clk),
        .rst_n     (rst_n),
        .sclIn     (sclIn),
        .sdaIn     (sdaIn),
        .sclRise   (sclRise),
        .sclFall   (sclFall),
        .startSeen (startSeen),
        .stopSeen  (stopSeen),
        .sdaLevel  (sdaLevel)
    );

    // Address compare includes bit 0, so reads are never acknowledged
    always_comb
    begin
        unique case (slaveAddrPin)
            ADDR_PIN_LOW:  ownAddr = SLAVE_ADDR_LOW;
            ADDR_PIN_HIGH: ownAddr = SLAVE_ADDR_HIGH;
            default:       ownAddr = SLAVE_ADDR_OPEN;
        endcase
    end

    assign subValid = (shift_q == SUB_CUTOFF) || (shift_q == SUB_INPUT_TYPE)
                      || (shift_q == SUB_OPERATING);
    // Eighth bit falls: byte complete, ack slot begins
    assign byteDone = sclFall && (bitCnt_q == 4'd8);

    // Bit shifting on SCL rise; ninth clock is the ack slot
    always_ff @(posedge clk)
    begin
        if (!rst_n || startSeen || stopSeen)
        begin
            shift_q  <= 8'h00;
            bitCnt_q <= 4'd0;
        end
        else if (sclRise && bitCnt_q != 4'd9)   // Eight data rises; ack rise not shifted
        begin
            shift_q  <= {shift_q[6:0], sdaLevel};
        end
        else if (sclFall)
        begin
            bitCnt_q <= (bitCnt_q == 4'd9) ? 4'd1 : bitCnt_q + 4'd1;
        end
    end

    // Phase tracking; no return to subaddress after data
    always_ff @(posedge clk)
    begin
        if (!rst_n || stopSeen)
        begin
            phase_q <= PH_IDLE;
        end
        else if (startSeen)
        begin
            phase_q <= PH_ADDR;
        end
        else if (byteDone)
        begin
            unique case (phase_q)
                PH_ADDR: phase_q <= (shift_q == ownAddr) ? PH_SUB : PH_IDLE;
                PH_SUB:  phase_q <= subValid ? PH_DATA : PH_IDLE;
                PH_DATA: phase_q <= PH_IDLE;
                PH_IDLE: phase_q <= PH_IDLE;
            endcase
        end
    end

    // Remember subaddress for the data byte
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sub_q <= 8'h00;
        end
        else if (byteDone && phase_q == PH_SUB)
        begin
            sub_q <= shift_q;
        end
    end

    // Ack driven low during the ninth clock only
    always_ff @(posedge clk)
    begin
        if (!rst_n || startSeen || stopSeen)
        begin
            ackDrive_q <= 1'b0;
        end
        else if (byteDone)
        begin
            ackDrive_q <= (phase_q == PH_ADDR && shift_q == ownAddr)
                          || (phase_q == PH_SUB && subValid)
                          || (phase_q == PH_DATA);
        end
        else if (sclFall)
        begin
            ackDrive_q <= 1'b0;
        end
    end

    assign sdaOut  = 1'b0;
    assign sdaOe_n = ~ackDrive_q;

    // Registers load at the start of the data ack, well inside 1 us
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cutoff_q    <= CUTOFF_RESET;
            inputType_q <= INPUT_TYPE_RESET;
            operating_q <= OPERATING_RESET;
        end
        else if (byteDone && phase_q == PH_DATA)
        begin
            unique case (sub_q)
                SUB_CUTOFF:     cutoff_q    <= shift_q;
                SUB_INPUT_TYPE: inputType_q <= shift_q[7:INPUT_TYPE_LSB];
                SUB_OPERATING:  operating_q <= shift_q[7:OPERATING_LSB];
                default:        cutoff_q    <= cutoff_q;
            endcase
        end
    end

    vfic_control_map u_map (
        .cutoffQ           (cutoff_q),
        .inputTypeQ        (inputType_q),
        .operatingQ        (operating_q),
        .inputBankPin      (inputBankPin),
        .cutoffRangeSelect (cutoffRangeSelect),
        .cutoffFineStep    (cutoffFineStep),
        .chanDirect        (chanDirect),
        .chanBias          (chanBias),
        .analogPowerdown   (analogPowerdown),
        .inputBankSelect   (inputBankSelect),
        .chanHalfCutoff    (chanHalfCutoff),
        .filterBypass      (filterBypass)
    );
    // Oversampling 100x at 400 kbit/s leaves margin for fast mode
endmodule // vfic_i2c_ctrl

// ===== test/vfic_checker.sv
// Assertion checker for the filter control port
`timescale 1ns/100ps
module vfic_checker
(
    // Clock, reset and bus
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sclIn,
    input wire logic       sdaOe_n,
    // Pin and controls
    input wire logic       inputBankPin,
    input wire logic       cutoffRangeSelect,
    input wire logic [6:0] cutoffFineStep,
    input wire logic [2:0] chanDirect,
    input wire logic [2:0] chanBias,
    input wire logic       analogPowerdown,
    input wire logic       inputBankSelect,
    input wire logic [2:0] chanHalfCutoff,
    input wire logic       filterBypass
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire [15:0] regs = {cutoffRangeSelect, cutoffFineStep, chanDirect, chanBias, analogPowerdown, filterBypass};
    a_ack_scl_low: assert property ($fell(sdaOe_n) |-> !sclIn)
        else $error("ack raised with SCL high");
    a_ack_hold: assert property ($fell(sdaOe_n) |=> !sdaOe_n [*8])
        else $error("ack too short");
    a_write_ack: assert property ($changed(regs) |-> $fell(sdaOe_n))
        else $error("control change without ack");
    a_reset_dflt: assert property ($rose(rst_n) |-> sdaOe_n && regs == 16'h0000)
        else $error("reset value wrong");
    a_bank_pin: assert property (inputBankPin |-> inputBankSelect)
        else $error("bank pin ignored");
    a_half_ch1: assert property (chanHalfCutoff[0] == 1'b0)
        else $error("channel 1 halved");
    a_half_pair: assert property (chanHalfCutoff[2] == chanHalfCutoff[1])
        else $error("half mode split");
    a_bypass_half: assert property (filterBypass |-> chanHalfCutoff == 3'h0)
        else $error("half mode in bypass");
endmodule // vfic_checker

bind vfic_i2c_ctrl vfic_checker i_vfic_checker (.clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaOe_n(sdaOe_n),
    .inputBankPin(inputBankPin), .cutoffRangeSelect(cutoffRangeSelect), .cutoffFineStep(cutoffFineStep),
    .chanDirect(chanDirect), .chanBias(chanBias), .analogPowerdown(analogPowerdown),
    .inputBankSelect(inputBankSelect), .chanHalfCutoff(chanHalfCutoff), .filterBypass(filterBypass));

// ===== test/vfic_i2c_master.sv
// Behavioural I2C bus master driving the control port
`timescale 1ns/100ps
module vfic_i2c_master
(
    // Bus
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      mSda
);
    // 110 clocks a bit keeps under 400 kbit/s
    initial {scl, mSda} = 2'b11;
    task automatic hw();
        repeat (50) @(posedge clk);
    endtask
    // Data moves well after SCL falls so it never looks like start or stop
    task automatic bit1(input logic b, output logic s);
        repeat (10) @(posedge clk);
        mSda <= b;
        hw();
        scl <= 1'b1;
        hw();
        s = sda;
        scl <= 1'b0;
    endtask
    // Start, address, sub, data, stop; one register a cycle
    task automatic wr(input logic [7:0] a, s, d, input int n, output logic [2:0] ack);
        logic [23:0] v;
        logic        x;
        v = {a, s, d};
        ack = 3'h0;
        mSda <= 1'b0;
        hw();
        scl <= 1'b0;
        for (int k = 2; k >= 0; k--)
        begin
            for (int i = 7; i >= 0; i--)
                if (k > 0 || i >= 8 - n) bit1(v[8 * k + i], x);
            if (k > 0 || n == 8) bit1(1'b1, x);
            if (k > 0 || n == 8) ack[k] = !x;
        end
        repeat (10) @(posedge clk);
        mSda <= 1'b0;
        hw();
        scl <= 1'b1;
        hw();
        mSda <= 1'b1;
        hw();
    endtask
endmodule // vfic_i2c_master

// ===== test/vfic_i2c_ctrl_tb_top.sv
// Self-checking bench for the filter control port
`timescale 1ns/100ps
module vfic_i2c_ctrl_tb_top;
    import vfic_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pin = 1'b0;
    logic        scl, mSda, sdaOut, sdaOe_n;
    logic [1:0]  ap = 2'h0;
    logic [2:0]  ack;
    logic [7:0]  cut = 8'h00, it = 8'h00, op = 8'h00;
    logic [19:0] m;
    logic [31:0] rs = 32'hD75EB792;
    int          err_count = 0, cmp_count = 0;
    wire  [19:0] got;
    wire         sda = mSda & (sdaOe_n | sdaOut);
    always #12.5 clk = ~clk;
    vfic_i2c_master i_vfic_i2c_master (.clk(clk), .sda(sda), .scl(scl), .mSda(mSda));
    vfic_i2c_ctrl i_vfic_i2c_ctrl (.clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .slaveAddrPin(ap), .inputBankPin(pin), .cutoffRangeSelect(got[19]),
        .cutoffFineStep(got[18:12]), .chanDirect(got[11:9]), .chanBias(got[8:6]), .analogPowerdown(got[5]),
        .inputBankSelect(got[4]), .chanHalfCutoff(got[3:1]), .filterBypass(got[0]));
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic chk(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Only the upper bits of the condition bytes count; bias is free under direct
    task automatic cmpo();
        logic [2:0] d;
        d = {it[3], it[5], it[7]};
        m = {cut, d, {it[2], it[4], it[6]} & ~d, op[7], pin | op[6], {2{op[5] & ~op[4]}}, 1'b0, op[4]};
        chk({got[19:9], got[8:6] & ~d, got[5:0]}, m); // Controls
    endtask
    task automatic xfer(input logic [7:0] a, s, d, input int n, input logic [2:0] ea);
        i_vfic_i2c_master.wr(a, s, d, n, ack);
        chk(ack, ea); // Acknowledge pattern
        if (ea == 3'h7)
            case (s)
                SUB_CUTOFF:     cut = d;
                SUB_INPUT_TYPE: it = d;
                default:        op = d;
            endcase
        cmpo(); // Refused or aborted cycles leave controls
    endtask
    initial
    begin
        repeat (90000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial
    begin
        logic [7:0]  a;
        logic [31:0] r;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmpo(); // Defaults
        for (int k = 0; k < 4; k++)
        begin
            ap <= k[1:0];
            pin <= k[0];
            @(posedge clk);
            a = k == 0 ? SLAVE_ADDR_LOW : k == 1 ? SLAVE_ADDR_HIGH : SLAVE_ADDR_OPEN; // Address by pin
            for (int s = 1; s < 4; s++)
            begin
                r = rnd();
                xfer(a, s[7:0], r[7:0], 8, 3'h7); // Subaddress decode
            end
            r = rnd();
            if (k < 2) xfer(k == 1 ? a | 8'h01 : a ^ 8'h04, SUB_CUTOFF, r[7:0], 8, 3'h0);
            else xfer(a, 8'h04 * k[7:0] - 8'h08, r[7:0], 8, 3'h4); // Bad subaddress
        end
        xfer(a, SUB_CUTOFF, ~cut, 4, 3'h6); // Abort in data byte
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        {cut, it, op} = 24'h000000;
        @(posedge clk);
        cmpo(); // Reset in mid-run
        r = rnd();
        xfer(a, SUB_OPERATING, r[7:0], 8, 3'h7); // Bus usable again after reset
        end_of_test();
    end
endmodule // vfic_i2c_ctrl_tb_top
